// [logic/tbg_burst_gate.v]
`timescale 1ns/1ns
`include "tbg_defines.vh"

// Notes on behaviour
// - burst mode: counted cycles per trigger edge
// - gated mode: output follows gate level
// - internal generator: divided square wave, equal halves
// - inexact period rounds up to step
// - generator square wave drives trigger output
// - internal burst: rising generator edge starts burst
// - internal gate: open during generator high half
// - external burst: rising input edge starts burst
// - external gate: open while input high
// - burst key toggles mode, lamp shows it
// - lamp flashes while trigger settings edited
// - three selectable trigger sources
// - manual key or remote command starts burst
// - report other users of internal generator
// - count 1..1023 whole or 1..2046 half cycles
// - burst starts and stops at phase setting
// - phase instants from auxiliary rising edges
// - no phase control for sine/triangle above 30kHz unless low aux
// - gate key toggles gated mode, lamp shows
// - gated output jumps between offset and waveform
// - manual gate: each press toggles gate
module tbg_burst_gate (
  input wire core_clk_in, // 25 MHz clock
  input wire reset_n_in, // async reset, active low
  input wire [7:0] addr_in, // register address
  input wire [31:0] wdata_in, // write data
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  output reg [31:0] rdata_out, // read data, cycle after strobe
  input wire external_trigger_input_in, // external trigger input
  input wire aux_in, // auxiliary output level
  input wire main_zero_in, // main output zero crossing, rising
  input wire [3:0] other_users_in, // G,F,A,T users of internal generator
  output wire main_enable_out, // main output gated on (else dc offset)
  output wire trigger_sweep_output, // internal generator square wave
  output wire burst_lamp_out, // burst key lamp
  output wire gate_lamp_out, // gate key lamp
  output wire burst_busy_out // burst in progress
);
  reg burst_on_reg;
  reg gate_on_reg;
  reg burst_mode_key_edit_reg;
  reg gate_edit_reg;
  reg half_reg;
  reg low_aux_reg;
  reg sine_tri_reg;
  reg above_30k_reg;
  reg [1:0] burst_src_reg;
  reg [1:0] gate_src_reg;
  reg [23:0] half_steps_reg;
  reg [10:0] count_reg;
  reg [7:0] pre_reg;
  reg [23:0] step_cnt_reg;
  reg gen_reg;
  reg gen_d_reg;
  reg ext_d_reg;
  reg aux_d_reg;
  reg zero_d_reg;
  reg man_gate_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [10:0] left_reg;
  reg [10:0] left_next;
  reg main_en_reg;
  reg [23:0] flash_cnt_reg;
  reg flash_reg;
  reg [2:0] burst_mode_key_count_reg;
  wire ext_sync;
  wire ext_rise;
  wire gen_rise;
  wire aux_rise;
  wire zero_rise;
  wire use_phase;
  wire edge_ev;
  wire man_ev;
  wire burst_mode_key_ev;
  wire gate_level;
  wire wr_keys;

  localparam ST_IDLE = 2'h0;
  localparam ST_ARM = 2'h1;
  localparam ST_RUN = 2'h2;

  tbg_sync u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(external_trigger_input_in),
    .sync_out(ext_sync)
  );

  assign wr_keys = wr_in && (addr_in == `TBG_ADDR_KEYS);
  assign man_ev = wr_keys && (wdata_in[`TBG_KEY_MANUAL] || wdata_in[`TBG_KEY_REMOTE]);
  assign ext_rise = ext_sync && !ext_d_reg;
  assign gen_rise = gen_reg && !gen_d_reg;
  assign aux_rise = aux_in && !aux_d_reg;
  assign zero_rise = main_zero_in && !zero_d_reg;
  assign use_phase = !(sine_tri_reg && above_30k_reg) || low_aux_reg;
  assign edge_ev = use_phase ? aux_rise : zero_rise;

  assign burst_mode_key_ev = (burst_src_reg == `TBG_SRC_EXT) ? ext_rise :
                   (burst_src_reg == `TBG_SRC_MAN) ? man_ev :
                   (burst_src_reg == `TBG_SRC_INT) ? gen_rise : 1'b0;

  assign gate_level = (gate_src_reg == `TBG_SRC_EXT) ? ext_sync :
                      (gate_src_reg == `TBG_SRC_MAN) ? man_gate_reg :
                      (gate_src_reg == `TBG_SRC_INT) ? gen_reg : 1'b0;

  // register writes and key toggles
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      burst_on_reg <= 1'b0;
      gate_on_reg <= 1'b0;
      burst_mode_key_edit_reg <= 1'b0;
      gate_edit_reg <= 1'b0;
      half_reg <= 1'b0;
      low_aux_reg <= 1'b0;
      sine_tri_reg <= 1'b0;
      above_30k_reg <= 1'b0;
      burst_src_reg <= `TBG_SRC_RST;
      gate_src_reg <= `TBG_SRC_RST;
      half_steps_reg <= `TBG_PERIOD_RST;
      count_reg <= `TBG_COUNT_RST;
      man_gate_reg <= 1'b0;
    end
    else
    begin
      if (wr_in && addr_in == `TBG_ADDR_CTRL)
      begin
        burst_mode_key_edit_reg <= wdata_in[`TBG_CTRL_BURST_MODE_KEY_EDIT];
        gate_edit_reg <= wdata_in[`TBG_CTRL_GATE_EDIT];
        half_reg <= wdata_in[`TBG_CTRL_HALF];
        low_aux_reg <= wdata_in[`TBG_CTRL_LOW_AUX];
        sine_tri_reg <= wdata_in[`TBG_CTRL_SINE_TRI];
        above_30k_reg <= wdata_in[`TBG_CTRL_ABOVE_30K];
      end
      if (wr_in && addr_in == `TBG_ADDR_SOURCE)
      begin
        if (wdata_in[1:0] != 2'h3)
          burst_src_reg <= wdata_in[1:0];
        if (wdata_in[3:2] != 2'h3)
          gate_src_reg <= wdata_in[3:2];
      end
      if (wr_in && addr_in == `TBG_ADDR_PERIOD)
      begin
        // half period in 10us steps; clamped to range
        if (wdata_in[23:0] < `TBG_HALF_MIN)
          half_steps_reg <= `TBG_HALF_MIN;
        else if (wdata_in[31:24] != 8'h00 || wdata_in[23:0] > `TBG_HALF_MAX)
          half_steps_reg <= `TBG_HALF_MAX;
        else
          half_steps_reg <= wdata_in[23:0];
      end
      if (wr_in && addr_in == `TBG_ADDR_COUNT)
      begin
        // half-cycle units: 1..2046
        if (wdata_in[10:0] == 11'h000)
          count_reg <= 11'h001;
        else if (wdata_in[10:0] == 11'h7FF)
          count_reg <= 11'h7FE;
        else
          count_reg <= wdata_in[10:0];
      end
      if (wr_keys && wdata_in[`TBG_KEY_BURST])
        burst_on_reg <= !burst_on_reg;
      if (wr_keys && wdata_in[`TBG_KEY_GATE])
        gate_on_reg <= !gate_on_reg;
      if (man_ev && gate_src_reg == `TBG_SRC_MAN)
        man_gate_reg <= !man_gate_reg;
    end
  end

  // internal generator: 10us step prescaler then half-period count
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pre_reg <= 8'h00;
      step_cnt_reg <= 24'h000000;
      gen_reg <= 1'b0;
    end
    else if (pre_reg == (`TBG_STEP_CYC - 1))
    begin
      pre_reg <= 8'h00;
      if (step_cnt_reg + 24'h000001 >= half_steps_reg)
      begin
        step_cnt_reg <= 24'h000000;
        gen_reg <= !gen_reg;
      end
      else
        step_cnt_reg <= step_cnt_reg + 24'h000001;
    end
    else
      pre_reg <= pre_reg + 8'h01;
  end

  // edge detect history
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      gen_d_reg <= 1'b0;
      ext_d_reg <= 1'b0;
      aux_d_reg <= 1'b0;
      zero_d_reg <= 1'b0;
    end
    else
    begin
      gen_d_reg <= gen_reg;
      ext_d_reg <= ext_sync;
      aux_d_reg <= aux_in;
      zero_d_reg <= main_zero_in;
    end
  end

  // burst sequencer
  always @*
  begin
    state_next = state_reg;
    left_next = left_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (burst_on_reg && !gate_on_reg && burst_mode_key_ev)
        begin
          state_next = ST_ARM;
          left_next = half_reg ? count_reg : {count_reg[9:0], 1'b0};
        end
      end
      ST_ARM:
      begin
        if (!burst_on_reg)
          state_next = ST_IDLE;
        else if (edge_ev)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        // each half cycle ends on an edge; half counts leave on opposite edge
        if (edge_ev || (aux_in != aux_d_reg && half_reg))
        begin
          if (!half_reg && !edge_ev)
            left_next = left_reg;
          else if (left_reg <= 11'h002 && !half_reg)
            state_next = ST_IDLE;
          else if (left_reg == 11'h001)
            state_next = ST_IDLE;
          else
            left_next = left_reg - (half_reg ? 11'h001 : 11'h002);
        end
        if (!burst_on_reg)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= ST_IDLE;
      left_reg <= 11'h000;
      main_en_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      left_reg <= left_next;
      if (gate_on_reg)
        main_en_reg <= gate_level;
      else if (burst_on_reg)
        main_en_reg <= (state_next == ST_RUN);
      else
        main_en_reg <= 1'b1;
    end
  end

  // lamp flashing while editing
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      flash_cnt_reg <= 24'h000000;
      flash_reg <= 1'b0;
    end
    else if (flash_cnt_reg == `TBG_FLASH_CYC)
    begin
      flash_cnt_reg <= 24'h000000;
      flash_reg <= !flash_reg;
    end
    else
      flash_cnt_reg <= flash_cnt_reg + 24'h000001;
  end

  // usage of the internal generator by this block
  always @*
  begin
    burst_mode_key_count_reg = 3'h0;
    if (burst_src_reg == `TBG_SRC_INT)
      burst_mode_key_count_reg = 3'h1;
  end

  // register read, data one cycle after strobe
  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_out <= 32'h00000000;
    else if (rd_in)
    begin
      case (addr_in)
        `TBG_ADDR_CTRL:
          rdata_out <= {24'h000000, above_30k_reg, sine_tri_reg, low_aux_reg, half_reg,
                        gate_edit_reg, burst_mode_key_edit_reg, gate_on_reg, burst_on_reg};
        `TBG_ADDR_SOURCE:
          rdata_out <= {28'h0000000, gate_src_reg, burst_src_reg};
        `TBG_ADDR_PERIOD:
          rdata_out <= {8'h00, half_steps_reg};
        `TBG_ADDR_COUNT:
          rdata_out <= {21'h00000, count_reg};
        `TBG_ADDR_STATUS:
          rdata_out <= {27'h000000, use_phase, ext_sync, gen_reg, state_reg};
        `TBG_ADDR_USAGE:
          // bit4 free, bits3:0 G,F,A,T in use
          rdata_out <= {27'h000000,
                        (other_users_in == 4'h0) && (gate_src_reg != `TBG_SRC_INT)
                          && (burst_mode_key_count_reg == 3'h0),
                        other_users_in[3] | (gate_src_reg == `TBG_SRC_INT),
                        other_users_in[2:1],
                        other_users_in[0] | burst_mode_key_count_reg[0]};
        default:
          rdata_out <= 32'h00000000;
      endcase
    end
    else
      rdata_out <= 32'h00000000;
  end

  assign main_enable_out = main_en_reg;
  assign trigger_sweep_output = gen_reg;
  assign burst_lamp_out = burst_mode_key_edit_reg ? flash_reg : burst_on_reg;
  assign gate_lamp_out = gate_edit_reg ? flash_reg : gate_on_reg;
  assign burst_busy_out = (state_reg != ST_IDLE);
endmodule

// [logic/tbg_defines.vh]
`ifndef TBG_DEFINES_VH
`define TBG_DEFINES_VH

// register offsets (word index, 8-bit address)
`define TBG_ADDR_CTRL 8'h00
`define TBG_ADDR_SOURCE 8'h01
`define TBG_ADDR_PERIOD 8'h02
`define TBG_ADDR_COUNT 8'h03
`define TBG_ADDR_STATUS 8'h04
`define TBG_ADDR_KEYS 8'h05
`define TBG_ADDR_USAGE 8'h06

// control register fields
`define TBG_CTRL_BURST_ON 0
`define TBG_CTRL_GATE_ON 1
`define TBG_CTRL_BURST_MODE_KEY_EDIT 2
`define TBG_CTRL_GATE_EDIT 3
`define TBG_CTRL_HALF 4
`define TBG_CTRL_LOW_AUX 5
`define TBG_CTRL_SINE_TRI 6
`define TBG_CTRL_ABOVE_30K 7

// keys register fields (write one to act)
`define TBG_KEY_BURST 0
`define TBG_KEY_GATE 1
`define TBG_KEY_MANUAL 2
`define TBG_KEY_REMOTE 3

// trigger source encodings
`define TBG_SRC_EXT 2'h0
`define TBG_SRC_MAN 2'h1
`define TBG_SRC_INT 2'h2

// internal generator and lamp flash timing, in ns, 10us steps and 25 MHz cycles
`define TBG_CLK_NS 40
`define TBG_STEP_NS 10000
`define TBG_STEP_CYC (`TBG_STEP_NS / `TBG_CLK_NS)
`define TBG_PERIOD_MIN_NS 20000
`define TBG_PERIOD_MAX_NS 200000000000
`define TBG_HALF_MIN 24'h000001
`define TBG_HALF_MAX 24'h989680
`define TBG_FLASH_CYC 24'h5F5E10

// reset values
`define TBG_PERIOD_RST 24'h000032
`define TBG_COUNT_RST 11'h002
`define TBG_SRC_RST 2'h0

`endif

// [logic/tbg_sync.v]
`timescale 1ns/1ns
// two-flop synchroniser for the external trigger level
module tbg_sync (
  input wire core_clk_in, // system clock
  input wire reset_n_in, // async reset, active low
  input wire async_in, // asynchronous level
  output wire sync_out // synchronised level
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// [testbench/tbg_burst_gate_asserts.sv]
`timescale 1ns/1ns
module tbg_burst_gate_asserts (
  input wire core_clk_in, // clock
  input wire reset_n_in, // reset, active low
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  input wire [31:0] rdata_out, // read data
  input wire external_trigger_input_in, // external trigger
  input wire aux_in, // aux level
  input wire main_enable_out, // output gate
  input wire trigger_sweep_output, // generator wave
  input wire burst_lamp_out, // burst lamp
  input wire gate_lamp_out, // gate lamp
  input wire burst_busy_out // burst busy
);
  reg [5:0] ext_h;
  reg [3:0] aux_h;
  reg [2:0] wr_h;
  reg [2:0] sw_h;
  reg [1:0] up_reg;
  reg seen_reg;
  reg [8:0] half_reg;
  wire ext_mv = ext_h != {6{external_trigger_input_in}};
  wire aux_mv = aux_h != {4{aux_in}};
  wire sw_mv = sw_h != {3{trigger_sweep_output}};
  wire wr_rc = wr_in || (|wr_h);
  wire up_ok = up_reg == 2'h3;
  // short input histories: any output change needs a recent cause
  always @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      ext_h <= 6'h00;
      aux_h <= 4'h0;
      wr_h <= 3'h0;
      sw_h <= 3'h0;
      up_reg <= 2'h0;
      seen_reg <= 1'b0;
      half_reg <= 9'h000;
    end
    else
    begin
      ext_h <= {ext_h[4:0], external_trigger_input_in};
      aux_h <= {aux_h[2:0], aux_in};
      wr_h <= {wr_h[1:0], wr_in};
      sw_h <= {sw_h[1:0], trigger_sweep_output};
      up_reg <= up_ok ? up_reg : up_reg + 2'h1;
      seen_reg <= seen_reg || (up_ok && sw_h[0] != trigger_sweep_output);
      half_reg <= (sw_h[0] != trigger_sweep_output) ? 9'h000 : half_reg + {8'h00, half_reg != 9'h1FF};
    end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_open;
    $rose(main_enable_out) && burst_busy_out;
  endsequence
  sequence s_close;
    up_ok && $fell(burst_busy_out);
  endsequence
  property p_rd_idle;
    !rd_in |=> rdata_out == 32'h00000000;
  endproperty
  property p_busy_cause;
    $rose(burst_busy_out) |-> ext_mv || sw_mv || wr_rc;
  endproperty
  property p_busy_end;
    s_close |-> aux_mv;
  endproperty
  property p_open_aux;
    s_open |-> aux_mv;
  endproperty
  property p_en_cause;
    up_ok && $changed(main_enable_out) |-> ext_mv || sw_mv || wr_rc || aux_mv;
  endproperty
  property p_half;
    seen_reg && $changed(trigger_sweep_output) |-> half_reg >= 9'h0F0;
  endproperty
  property p_blamp;
    up_ok && $changed(burst_lamp_out) |-> wr_rc;
  endproperty
  property p_glamp;
    up_ok && $changed(gate_lamp_out) |-> wr_rc;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_busy_cause: assert property (p_busy_cause) else $error("burst without trigger");
  a_busy_end: assert property (p_busy_end) else $error("burst end off aux edge");
  a_open_aux: assert property (p_open_aux) else $error("burst start off aux edge");
  a_en_cause: assert property (p_en_cause) else $error("gate moved without cause");
  a_half: assert property (p_half) else $error("generator half too short");
  a_blamp: assert property (p_blamp) else $error("burst lamp moved alone");
  a_glamp: assert property (p_glamp) else $error("gate lamp moved alone");
endmodule

// [testbench/tbg_far_model.sv]
`timescale 1ns/1ns
module tbg_far_model #(
  parameter int AUX_HALF = 12
) (
  input wire core_clk_in, // clock
  output logic aux_out, // auxiliary level
  output logic zero_out, // main phase-zero level
  output logic ext_out // external trigger
);
  int ph = 0;
  initial
  begin
    aux_out = 1'b0;
    zero_out = 1'b0;
    ext_out = 1'b0;
  end
  // phase setting zero, so aux and zero edges coincide
  always @(posedge core_clk_in)
  begin
    ph <= (ph == 2 * AUX_HALF - 1) ? 0 : ph + 1;
    aux_out <= ph < AUX_HALF;
    zero_out <= ph < AUX_HALF;
  end
  // pulse of w clocks, at least 2 wide, then a gap to 25 clocks per pulse
  task automatic pulse(input int w);
    @(posedge core_clk_in);
    ext_out <= 1'b1;
    repeat ((w < 2) ? 2 : w) @(posedge core_clk_in);
    ext_out <= 1'b0;
    repeat ((w < 24) ? 25 - w : 1) @(posedge core_clk_in);
  endtask
endmodule

// [testbench/triggered_burst_and_gate_control_tb_top.sv]
`timescale 1ns/1ns
`include "tbg_defines.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %0h not %0h", $time, (a), (b)); end end
module triggered_burst_and_gate_control_tb_top;
  localparam int AH = 12;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] users = 4'h0;
  logic [3:0] u;
  wire [31:0] rdata;
  wire external_source, aux, zero, en, sweep, blamp, glamp, busy;
  int fails = 0, n_compared = 0, cyc = 0, seed = 32'hA08C, en_cnt = 0, base, n, k, cnt;
  tbg_burst_gate dut_u (.core_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .external_trigger_input_in(external_source),
    .aux_in(aux), .main_zero_in(zero), .other_users_in(users), .main_enable_out(en),
    .trigger_sweep_output(sweep), .burst_lamp_out(blamp), .gate_lamp_out(glamp),
    .burst_busy_out(busy));
  tbg_far_model #(.AUX_HALF(AH)) far_u (.core_clk_in(clk), .aux_out(aux), .zero_out(zero),
    .ext_out(external_source));
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    en_cnt <= en_cnt + (en === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end
  task automatic results;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, v)
  endtask
  // bounded wait on busy (which 0) or generator wave (which 1)
  task automatic wait_sig(input int which, input logic v);
    n = 0;
    while (((which == 1) ? sweep : busy) !== v && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  // how: 0 external, 1 internal, 2 manual key, 3 remote command
  task automatic burst_run(input int how, input int ex);
    base = en_cnt;
    if (how == 0)
      far_u.pulse(3);
    else if (how == 1)
    begin
      wait_sig(1, 1'b0);
      base = en_cnt;
      wait_sig(1, 1'b1);
    end
    else
      wr_reg(`TBG_ADDR_KEYS, 32'h1 << how);
    wait_sig(0, 1'b1);
    `CHK(busy, 1'b1)
    `CHK(how != 1 || n <= 4, 1'b1)
    if (how == 0)
      far_u.pulse(3);
    wait_sig(0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK((en_cnt - base) inside {[ex - 1:ex + 1]}, 1'b1)
    repeat (40) @(posedge clk);
    `CHK(busy, 1'b0)
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(en, 1'b1)
    `CHK({blamp, glamp, busy}, 3'h0)
    rd_chk(`TBG_ADDR_SOURCE, 32'h0);
    rd_chk(`TBG_ADDR_PERIOD, 32'h32);
    rd_chk(`TBG_ADDR_COUNT, 32'h2);
    rd_chk(8'h07, 32'h0);
    wr_reg(`TBG_ADDR_COUNT, 32'h0);
    rd_chk(`TBG_ADDR_COUNT, 32'h1);
    wr_reg(`TBG_ADDR_COUNT, 32'h3FF);
    rd_chk(`TBG_ADDR_COUNT, 32'h3FF);
    wr_reg(`TBG_ADDR_PERIOD, 32'h0FFFFFFF);
    rd_chk(`TBG_ADDR_PERIOD, 32'h989680);
    wr_reg(`TBG_ADDR_PERIOD, 32'h0);
    rd_chk(`TBG_ADDR_PERIOD, 32'h1);
    wr_reg(`TBG_ADDR_KEYS, 32'h1);
    rd_chk(`TBG_ADDR_CTRL, 32'h1);
    `CHK(blamp, 1'b1)
    wr_reg(`TBG_ADDR_CTRL, 32'h4);
    #1;
    `CHK(blamp, 1'b0)
    rd_chk(`TBG_ADDR_CTRL, 32'h5);
    for (k = 0; k < 2; k++)
    begin
      cnt = 4 + ($random(seed) & 3);
      wr_reg(`TBG_ADDR_CTRL, k << 4);
      wr_reg(`TBG_ADDR_COUNT, cnt);
      burst_run(0, cnt * AH * (2 - k));
    end
    wr_reg(`TBG_ADDR_CTRL, 32'h0);
    wr_reg(`TBG_ADDR_SOURCE, 32'h1);
    for (k = 2; k < 4; k++)
      burst_run(k, cnt * AH * 2);
    wr_reg(`TBG_ADDR_SOURCE, 32'h2);
    burst_run(1, cnt * AH * 2);
    wait_sig(1, 1'b0);
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    `CHK(n inside {[249:251]}, 1'b1)
    rd_chk(`TBG_ADDR_STATUS, 32'h10);
    wr_reg(`TBG_ADDR_CTRL, 32'hC0);
    rd_chk(`TBG_ADDR_STATUS, 32'h0);
    wr_reg(`TBG_ADDR_CTRL, 32'hE0);
    rd_chk(`TBG_ADDR_STATUS, 32'h10);
    wr_reg(`TBG_ADDR_CTRL, 32'h0);
    wr_reg(`TBG_ADDR_KEYS, 32'h3);
    rd_chk(`TBG_ADDR_CTRL, 32'h2);
    `CHK({blamp, glamp}, 2'h1)
    wr_reg(`TBG_ADDR_SOURCE, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(en, 1'b0)
    base = en_cnt;
    far_u.pulse(20);
    repeat (5) @(posedge clk);
    `CHK((en_cnt - base) inside {[19:21]}, 1'b1)
    wr_reg(`TBG_ADDR_SOURCE, 32'h4);
    for (k = 2; k < 4; k++)
    begin
      wr_reg(`TBG_ADDR_KEYS, 32'h1 << k);
      repeat (3) @(posedge clk);
      `CHK(en, k == 2)
    end
    wr_reg(`TBG_ADDR_SOURCE, 32'h8);
    base = en_cnt;
    repeat (1000) @(posedge clk);
    `CHK((en_cnt - base) inside {[498:502]}, 1'b1)
    wr_reg(`TBG_ADDR_SOURCE, 32'h0);
    for (k = 0; k < 2; k++)
    begin
      u = (k == 0) ? 4'($random(seed)) : 4'h0;
      users <= u;
      rd_chk(`TBG_ADDR_USAGE, {27'h0, u == 4'h0, u});
    end
    wr_reg(`TBG_ADDR_SOURCE, 32'hA);
    rd_chk(`TBG_ADDR_USAGE, 32'h9);
    results();
  end
endmodule
bind tbg_burst_gate tbg_burst_gate_asserts chk_u (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .external_trigger_input_in(external_trigger_input_in), .aux_in(aux_in), .main_enable_out(main_enable_out),
  .trigger_sweep_output(trigger_sweep_output), .burst_lamp_out(burst_lamp_out),
  .gate_lamp_out(gate_lamp_out), .burst_busy_out(burst_busy_out));
